/* File: rtl/pin_level_status.v */
// Level-sensitive pin interrupt status with minimum-width filter and write-one-to-clear
`timescale 1ns/10ps
`include "csr_defs.vh"
module pin_level_status #(
    parameter WIDTH = 8
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] pin_level,
    input  wire [WIDTH-1:0] trigger_high,
    input  wire [WIDTH-1:0] clear_mask,
    output wire [WIDTH-1:0] status
);
    localparam FILTER = (`PIN_MIN_ACTIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [1:0] FILTER_CNT = FILTER[1:0];

    reg  [WIDTH-1:0] status_reg;
    wire [WIDTH-1:0] seen;
    genvar i;

    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            reg  [1:0] cnt_reg;
            // Polarity chosen per pin: high level or low level
            wire       active = trigger_high[i] ? pin_level[i] : ~pin_level[i];
            always @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_reg <= 2'h0;
                end else if (!active) begin
                    cnt_reg <= 2'h0;
                end else if (cnt_reg != FILTER_CNT) begin
                    cnt_reg <= cnt_reg + 2'h1;
                end
            end
            // Level must stay active across the minimum time to count
            assign seen[i] = active && (cnt_reg == FILTER_CNT - 2'h1 || cnt_reg == FILTER_CNT);
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= {WIDTH{1'b0}};
        end else begin
            // Set regardless of enable, set wins over clear
            status_reg <= (status_reg & ~clear_mask) | seen;
        end
    end

    assign status = status_reg;
endmodule // pin_level_status

/* File: rtl/ready_sequencer.v */
// Device reset and ready sequencing after power-up, digital reset and power saving
`timescale 1ns/10ps
`include "csr_defs.vh"
module ready_sequencer (
    input  wire aclk,
    input  wire aresetn,
    input  wire digital_reset,
    input  wire power_save,
    output reg  in_reset,
    output reg  ready
);
    localparam HOLD   = (`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam STABLE = (`STABLE_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [7:0] HOLD_CNT   = HOLD[7:0];
    localparam [7:0] STABLE_CNT = STABLE[7:0];
    localparam [3:0] S_RESET  = 4'h1;
    localparam [3:0] S_STABLE = 4'h2;
    localparam [3:0] S_READY  = 4'h4;
    localparam [3:0] S_SLEEP  = 4'h8;

    reg [3:0] state_reg;
    reg [7:0] cnt_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= S_RESET;
            cnt_reg   <= 8'h00;
            in_reset  <= 1'b1;
            ready     <= 1'b0;
        end else if (digital_reset) begin
            state_reg <= S_RESET;
            cnt_reg   <= 8'h00;
            in_reset  <= 1'b1;
            ready     <= 1'b0;
        end else begin
            case (state_reg)
                S_RESET: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == HOLD_CNT - 8'h01) begin
                        state_reg <= S_STABLE;
                        cnt_reg   <= 8'h00;
                        in_reset  <= 1'b0;
                    end
                end
                S_STABLE: begin
                    if (power_save) begin
                        state_reg <= S_SLEEP;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                        if (cnt_reg == STABLE_CNT - 8'h01) begin
                            state_reg <= S_READY;
                            ready     <= 1'b1; // Set once logic is stable
                        end
                    end
                end
                S_READY: begin
                    if (power_save) begin
                        state_reg <= S_SLEEP;
                        ready     <= 1'b0; // Low while power saving
                    end
                end
                S_SLEEP: begin
                    if (!power_save) begin
                        state_reg <= S_STABLE;
                        cnt_reg   <= 8'h00;
                    end
                end
                default: begin
                    state_reg <= S_RESET;
                    cnt_reg   <= 8'h00;
                    in_reset  <= 1'b1;
                    ready     <= 1'b0;
                end
            endcase
        end
    end
endmodule // ready_sequencer

/* File: rtl/system_csr_bank.v */
// System CSR slice: pin interrupts, identity, byte order, ready, AXI4-Lite slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`include "csr_defs.vh"
module system_csr_bank #(
    parameter        PINS     = 8,
    parameter [15:0] CHIP_ID  = 16'h0C5A, // Arbitrary value
    parameter [15:0] REVISION = 16'h0001
) (
    input  wire                 aclk,
    input  wire                 aresetn,
    input  wire [`ADDR_W-1:0]   s_axi_awaddr,
    input  wire [2:0]           s_axi_awprot,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [`ADDR_W-1:0]   s_axi_araddr,
    input  wire [2:0]           s_axi_arprot,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    input  wire [PINS-1:0]      pin_level,
    input  wire [PINS-1:0]      pin_trigger_high,
    input  wire                 power_save,
    output reg                  irq,
    output reg                  gpio_event,
    output reg                  device_ready
);
    // Chip identity value is arbitrary
    localparam [31:0] ID_WORD = {CHIP_ID, REVISION};

    reg  [`ADDR_W-1:0] aw_addr_reg;
    reg                aw_full_reg;
    reg  [31:0]        w_data_reg;
    reg  [3:0]         w_strb_reg;
    reg                w_full_reg;
    reg  [PINS-1:0]    pin_en_reg;
    reg                top_gpio_en_reg;
    reg                top_ready_en_reg;
    reg                ready_sts_reg;
    reg                ready_prev_reg;
    reg                digital_reset_reg;
    reg  [PINS-1:0]    pin_clear_next;
    reg  [31:0]        rdata_next;
    reg  [1:0]         rresp_next;
    reg                wr_hit;
    wire [PINS-1:0]    pin_status;
    wire               in_reset;
    wire               ready;
    wire               do_write;
    wire               gpio_event_next;
    wire               ready_rise;
    wire [`ADDR_W-1:0] wr_addr;
    wire [`ADDR_W-1:0] rd_addr;

    // Word address of a byte address; any byte of a word selects the word
    function [`ADDR_W-1:0] word_of;
        input [`ADDR_W-1:0] addr;
        begin
            word_of = addr & `WORD_MASK;
        end
    endfunction

    pin_level_status #(
        .WIDTH (PINS)
    ) u_pins (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .pin_level    (pin_level),
        .trigger_high (pin_trigger_high),
        .clear_mask   (pin_clear_next),
        .status       (pin_status)
    );

    ready_sequencer u_ready (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .digital_reset (digital_reset_reg),
        .power_save    (power_save),
        .in_reset      (in_reset),
        .ready         (ready)
    );

    assign wr_addr         = word_of(aw_addr_reg);
    assign rd_addr         = word_of(s_axi_araddr);
    assign do_write        = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign gpio_event_next = |(pin_status & pin_en_reg);
    assign ready_rise      = ready && !ready_prev_reg;

    // Write address and data are taken independently
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg   <= 1'b0;
            aw_addr_reg   <= {`ADDR_W{1'b0}};
            w_full_reg    <= 1'b0;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_full_reg && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_full_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_reg && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_full_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Write decode; writes made before ready are dropped but answered
    always @* begin
        wr_hit         = 1'b0;
        pin_clear_next = {PINS{1'b0}};
        case (wr_addr)
            `OFF_CHIP_CHIP_IDENTITY_REVISION,
            `OFF_BYTE_ORDER,
            `OFF_HW_CONFIG,
            `OFF_POWER_MGMT_CTRL,
            `OFF_TOP_INT_ENABLE,
            `OFF_TOP_INT_STATUS,
            `OFF_RESET_CONTROL:    wr_hit = 1'b1; // Read-only ones ignore writes
            `OFF_PIN_TOP_INTERRUPT_STATUS_EN: begin
                wr_hit = 1'b1;
                if (do_write && ready && w_strb_reg[`PIN_STS_LANE]) begin
                    pin_clear_next = w_data_reg[`PIN_STS_LSB +: PINS];
                end
            end
            default:               wr_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_en_reg        <= {PINS{1'b0}};
            top_gpio_en_reg   <= 1'b0;
            top_ready_en_reg  <= 1'b0;
            digital_reset_reg <= 1'b0;
        end else begin
            digital_reset_reg <= 1'b0;
            if (do_write && ready) begin
                if (wr_addr == `OFF_PIN_TOP_INTERRUPT_STATUS_EN && w_strb_reg[`PIN_EN_LANE]) begin
                    pin_en_reg <= w_data_reg[`PIN_EN_LSB +: PINS];
                end
                if (wr_addr == `OFF_TOP_INT_ENABLE) begin
                    if (w_strb_reg[`TOP_GPIO_BIT / 8]) begin
                        top_gpio_en_reg <= w_data_reg[`TOP_GPIO_BIT];
                    end
                    if (w_strb_reg[`TOP_READY_BIT / 8]) begin
                        top_ready_en_reg <= w_data_reg[`TOP_READY_BIT];
                    end
                end
                if (wr_addr == `OFF_RESET_CONTROL && w_strb_reg[`RESET_DIGITAL_BIT / 8]) begin
                    digital_reset_reg <= w_data_reg[`RESET_DIGITAL_BIT];
                end
            end
        end
    end

    // Device-ready event is sticky; a new rise wins over a clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            ready_prev_reg <= 1'b0;
            ready_sts_reg  <= 1'b0;
        end else begin
            ready_prev_reg <= ready;
            if (ready_rise) begin
                ready_sts_reg <= 1'b1;
            end else if (do_write && ready && wr_addr == `OFF_TOP_INT_STATUS
                         && w_strb_reg[`TOP_READY_BIT / 8] && w_data_reg[`TOP_READY_BIT]) begin
                ready_sts_reg <= 1'b0;
            end
        end
    end

    // Read decode; unused bits stay zero
    always @* begin
        rdata_next = 32'h00000000;
        rresp_next = `RESP_OKAY;
        case (rd_addr)
            `OFF_CHIP_CHIP_IDENTITY_REVISION:     rdata_next = ID_WORD;
            `OFF_BYTE_ORDER:      rdata_next = in_reset ? `BYTE_ORDER_IN_RESET
                                                        : `BYTE_ORDER_PATTERN;
            `OFF_HW_CONFIG:       rdata_next[`HARDWARE_CONFIGURATION_READY_BIT] = ready;
            `OFF_POWER_MGMT_CTRL: rdata_next[`PMT_READY_BIT] = ready;
            `OFF_TOP_INT_STATUS: begin
                rdata_next[`TOP_GPIO_BIT]  = gpio_event;
                rdata_next[`TOP_READY_BIT] = ready_sts_reg;
            end
            `OFF_TOP_INT_ENABLE: begin
                rdata_next[`TOP_GPIO_BIT]  = top_gpio_en_reg;
                rdata_next[`TOP_READY_BIT] = top_ready_en_reg;
            end
            `OFF_RESET_CONTROL:   rdata_next = 32'h00000000;
            `OFF_PIN_TOP_INTERRUPT_STATUS_EN: begin
                rdata_next[`PIN_STS_LSB +: PINS] = pin_status;
                rdata_next[`PIN_EN_LSB +: PINS]  = pin_en_reg;
            end
            default:              rresp_next = `RESP_DECERR;
        endcase
    end

    // Full word always returned, so byte reads need no pairing
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdata_next;
                s_axi_rresp   <= rresp_next;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            gpio_event   <= 1'b0;
            irq          <= 1'b0;
            device_ready <= 1'b0;
        end else begin
            gpio_event   <= gpio_event_next;
            device_ready <= ready;
            irq          <= (gpio_event_next && top_gpio_en_reg)
                            || (ready_sts_reg && top_ready_en_reg);
        end
    end
endmodule // system_csr_bank

/* File: shared/csr_defs.vh */
// Constants for the system CSR slice: offsets, fields, reset values and timing
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

`define ADDR_W               12
`define WORD_MASK            12'hFFC

`define OFF_CHIP_CHIP_IDENTITY_REVISION      12'h050
`define OFF_TOP_INT_STATUS   12'h058
`define OFF_TOP_INT_ENABLE   12'h05C
`define OFF_BYTE_ORDER       12'h064
`define OFF_HW_CONFIG        12'h074
`define OFF_POWER_MGMT_CTRL  12'h084
`define OFF_PIN_TOP_INTERRUPT_STATUS_EN   12'h1E8
`define OFF_RESET_CONTROL    12'h1F8

`define BYTE_ORDER_PATTERN   32'h87654321
`define BYTE_ORDER_IN_RESET  32'h00000000
`define PIN_STS_LSB          0
`define PIN_EN_LSB           16
`define PIN_STS_LANE         0
`define PIN_EN_LANE          2
`define HARDWARE_CONFIGURATION_READY_BIT     27
`define PMT_READY_BIT        0
`define TOP_GPIO_BIT         12
`define TOP_READY_BIT        30
`define RESET_DIGITAL_BIT    0
`define ID_LSB               16

`define RESP_OKAY            2'h0
`define RESP_DECERR          2'h3

`define CLK_PERIOD_NS        25
`define PIN_MIN_ACTIVE_NS    40
`define RESET_HOLD_NS        200
`define STABLE_WAIT_NS       1000

`endif

/* File: testbench/csr_bank_properties.sv */
// Port-level assertions for the system CSR slice
`timescale 1ns/10ps
`include "csr_defs.vh"
module csr_bank_properties #(
    parameter PINS = 8
) (
    input wire               aclk,
    input wire               aresetn,
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire               s_axi_awvalid,
    input wire               s_axi_awready,
    input wire [1:0]         s_axi_bresp,
    input wire               s_axi_bvalid,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire               s_axi_arvalid,
    input wire               s_axi_arready,
    input wire [31:0]        s_axi_rdata,
    input wire [1:0]         s_axi_rresp,
    input wire               s_axi_rvalid,
    input wire               power_save,
    input wire               gpio_event,
    input wire               device_ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reg aw_bad_reg = 1'b0;

    function automatic bit unmapped(input [`ADDR_W-1:0] a);
        case (a & `WORD_MASK)
            `OFF_CHIP_CHIP_IDENTITY_REVISION, `OFF_TOP_INT_STATUS, `OFF_TOP_INT_ENABLE, `OFF_BYTE_ORDER,
            `OFF_HW_CONFIG, `OFF_POWER_MGMT_CTRL, `OFF_PIN_TOP_INTERRUPT_STATUS_EN, `OFF_RESET_CONTROL:
                unmapped = 1'b0;
            default: unmapped = 1'b1;
        endcase
    endfunction

    // Remembers whether the last accepted write address hit a register
    always @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_bad_reg <= unmapped(s_axi_awaddr);
    end

    sequence s_reset_exit; $rose(aresetn); endsequence
    sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence

    property p_ready_low; s_reset_exit |-> !device_ready [*8]; endproperty
    a_ready_low: assert property (p_ready_low)
        else $error("ready high too soon after reset");
    property p_ready_rises; s_reset_exit |-> ##[30:60] device_ready; endproperty
    a_ready_rises: assert property (p_ready_rises)
        else $error("ready never rose after reset");
    property p_sleep_drops; power_save |-> ##[1:3] !device_ready; endproperty
    a_sleep_drops: assert property (p_sleep_drops)
        else $error("ready stayed high in power saving");
    property p_pattern;
        s_ar_taken ##0 ((s_axi_araddr & `WORD_MASK) == `OFF_BYTE_ORDER && device_ready)
            |-> s_axi_rdata == `BYTE_ORDER_PATTERN;
    endproperty
    a_pattern: assert property (p_pattern)
        else $error("byte order pattern wrong");
    property p_rd_unmapped;
        s_ar_taken ##0 unmapped(s_axi_araddr) |-> s_axi_rresp == `RESP_DECERR && s_axi_rdata == 0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not refused");
    property p_wr_unmapped; $rose(s_axi_bvalid) && aw_bad_reg |-> s_axi_bresp == `RESP_DECERR; endproperty
    a_wr_unmapped: assert property (p_wr_unmapped)
        else $error("unmapped write not refused");
    property p_read_answer; s_ar_taken |-> s_axi_rvalid; endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read data missing at address accept");
    property p_write_answer; s_axi_awvalid && s_axi_awready |-> ##[0:4] s_axi_bvalid; endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response late");
    property p_no_event; s_reset_exit |-> !gpio_event [*2]; endproperty
    a_no_event: assert property (p_no_event)
        else $error("pin event right after reset");
endmodule // csr_bank_properties

bind system_csr_bank csr_bank_properties #(.PINS(PINS)) u_csr_bank_properties (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .power_save, .gpio_event, .device_ready
);

/* File: testbench/host_bus_model.sv */
// Host processor model: AXI4-Lite master issuing single register accesses
`timescale 1ns/10ps
`include "csr_defs.vh"
module host_bus_model (
    input  wire               aclk,
    output reg  [`ADDR_W-1:0] awaddr  = 0,
    output reg                awvalid = 1'b0,
    input  wire               awready,
    output reg  [31:0]        wdata   = 0,
    output reg  [3:0]         wstrb   = 4'h0,
    output reg                wvalid  = 1'b0,
    input  wire               wready,
    input  wire [1:0]         bresp,
    input  wire               bvalid,
    output reg                bready  = 1'b0,
    output reg  [`ADDR_W-1:0] araddr  = 0,
    output reg                arvalid = 1'b0,
    input  wire               arready,
    input  wire [31:0]        rdata,
    input  wire [1:0]         rresp,
    input  wire               rvalid,
    output reg                rready  = 1'b0
);
    // Released address and data lines carry the inverse of the last value; wstrb keeps it
    task write(input [`ADDR_W-1:0] a, input [31:0] d, input [3:0] s, output [1:0] resp);
        begin
            @(posedge aclk);
            awaddr <= a;
            awvalid <= 1'b1;
            wdata <= d;
            wstrb <= s;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge aclk);
                if (awready) begin
                    awvalid <= 1'b0;
                    awaddr <= ~a;
                end
                if (wready) begin
                    wvalid <= 1'b0;
                    wdata <= ~d;
                end
            end while (!bvalid);
            resp = bresp;
            bready <= 1'b0;
        end
    endtask

    task read(input [`ADDR_W-1:0] a, output [31:0] d, output [1:0] resp);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge aclk);
                if (arready) begin
                    arvalid <= 1'b0;
                    araddr <= ~a;
                end
            end while (!rvalid);
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
        end
    endtask
endmodule // host_bus_model

/* File: testbench/tb.sv */
// Self-checking bench for the system CSR slice
`timescale 1ns/10ps
`include "csr_defs.vh"
module tb;
    localparam [15:0] CHIP_ID  = 16'h1A2B; // Arbitrary identity code
    localparam [15:0] REVISION = 16'h0003; // Arbitrary revision code
    reg                aclk, aresetn, power_save;
    reg  [7:0]         pin_level, pin_trigger_high, lvl, trig;
    wire               irq, gpio_event, device_ready;
    wire [`ADDR_W-1:0] awaddr, araddr;
    wire [31:0]        wdata, rdata;
    wire [3:0]         wstrb;
    wire [1:0]         bresp, rresp;
    wire               awvalid, awready, wvalid, wready, bvalid, bready;
    wire               arvalid, arready, rvalid, rready;
    integer            failures, num_checks, seed, i;
    reg  [31:0]        rd;
    reg  [1:0]         rs;

    system_csr_bank #(.PINS(8), .CHIP_ID(CHIP_ID), .REVISION(REVISION)) u_system_csr_bank (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_level(pin_level),
        .pin_trigger_high(pin_trigger_high), .power_save(power_save), .irq(irq),
        .gpio_event(gpio_event), .device_ready(device_ready));

    host_bus_model u_host_bus_model (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    function [7:0] exp_status(input [7:0] l, input [7:0] t);
        exp_status = ~(l ^ t);
    endfunction

    task check(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task rd_chk(input [`ADDR_W-1:0] a, input [31:0] exp);
        begin
            u_host_bus_model.read(a, rd, rs);
            check(rd, exp);
        end
    endtask

    task wr(input [`ADDR_W-1:0] a, input [31:0] d, input [3:0] s);
        u_host_bus_model.write(a, d, s, rs);
    endtask

    task cycles(input integer n);
        repeat (n) @(posedge aclk);
    endtask

    task wait_ready;
        integer n;
        begin
            n = 0;
            rd = 32'h0;
            while (rd[`HARDWARE_CONFIGURATION_READY_BIT] !== 1'b1 && n < 200) begin
                u_host_bus_model.read(`OFF_HW_CONFIG, rd, rs);
                n = n + 1;
            end
            check({31'h0, rd[`HARDWARE_CONFIGURATION_READY_BIT]}, 32'h1);
        end
    endtask

    task tally_and_finish;
        begin
            $display("checks %0d failures %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    initial begin
        #(25 * 20000);
        failures = failures + 1;
        tally_and_finish;
    end

    initial begin
        failures = 0;
        num_checks = 0;
        seed = 1452;
        aresetn = 1'b0;
        power_save = 1'b0;
        pin_trigger_high = 8'hFF;
        pin_level = 8'h00;
        cycles(6);
        aresetn <= 1'b1;
        // Only permitted registers are read while not ready
        u_host_bus_model.read(`OFF_BYTE_ORDER, rd, rs);
        check({31'h0, rd === `BYTE_ORDER_PATTERN}, 32'h0);
        rd_chk(`OFF_HW_CONFIG, 32'h0);
        wr(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h00FF0000, 4'hF);
        wait_ready;
        rd_chk(`OFF_POWER_MGMT_CTRL, 32'h1);
        rd_chk(`OFF_TOP_INT_STATUS, 32'h40000000);
        rd_chk(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h0);
        wr(`OFF_CHIP_CHIP_IDENTITY_REVISION, 32'hFFFFFFFF, 4'hF);
        rd_chk(`OFF_CHIP_CHIP_IDENTITY_REVISION, {CHIP_ID, REVISION});
        wr(`OFF_BYTE_ORDER, 32'h0, 4'hF);
        rd_chk(`OFF_BYTE_ORDER + 12'h001, `BYTE_ORDER_PATTERN);
        rd_chk(12'h100, 32'h0);
        check({30'h0, rs}, {30'h0, `RESP_DECERR});
        wr(12'h100, 32'hFFFFFFFF, 4'hF);
        check({30'h0, rs}, {30'h0, `RESP_DECERR});
        // One-cycle pulse is shorter than the recognition time
        pin_level <= 8'h01;
        cycles(1);
        pin_level <= 8'h00;
        cycles(3);
        rd_chk(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h0);
        pin_level <= 8'h04;
        cycles(3);
        pin_level <= 8'h00;
        cycles(2);
        rd_chk(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h00000004);
        check({30'h0, gpio_event, irq}, 32'h0);
        wr(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h00040000, 4'h4);
        cycles(2);
        check({30'h0, gpio_event, irq}, 32'h2);
        rd_chk(`OFF_TOP_INT_STATUS, 32'h40001000);
        wr(`OFF_TOP_INT_ENABLE, 32'h00001000, 4'hF);
        cycles(2);
        check({31'h0, irq}, 32'h1);
        wr(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h000000FB, 4'h1);
        rd_chk(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h00040004);
        wr(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'hFFFFFF04, 4'h1);
        cycles(2);
        check({30'h0, gpio_event, irq}, 32'h0);
        wr(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'hFFFFFFFF, 4'hF);
        rd_chk(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h00FF0000);
        for (i = 0; i < 8; i = i + 1) begin
            trig = $random(seed);
            lvl = $random(seed);
            pin_trigger_high <= trig;
            pin_level <= ~trig;
            wr(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h000000FF, 4'h1);
            pin_level <= lvl;
            cycles(4);
            pin_level <= ~trig;
            cycles(2);
            rd_chk(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, {16'h00FF, 8'h00, exp_status(lvl, trig)});
            check({31'h0, gpio_event}, {31'h0, |exp_status(lvl, trig)});
        end
        wr(`OFF_TOP_INT_STATUS, 32'h40000000, 4'hF);
        power_save <= 1'b1;
        cycles(4);
        rd_chk(`OFF_HW_CONFIG, 32'h0);
        rd_chk(`OFF_BYTE_ORDER, `BYTE_ORDER_PATTERN);
        wr(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, 32'h0, 4'h4);
        power_save <= 1'b0;
        wait_ready;
        rd_chk(`OFF_POWER_MGMT_CTRL, 32'h1);
        u_host_bus_model.read(`OFF_TOP_INT_STATUS, rd, rs);
        check({31'h0, rd[`TOP_READY_BIT]}, 32'h1);
        u_host_bus_model.read(`OFF_PIN_TOP_INTERRUPT_STATUS_EN, rd, rs);
        check({24'h0, rd[23:16]}, 32'hFF);
        wr(`OFF_RESET_CONTROL, 32'h00000001, 4'h1);
        u_host_bus_model.read(`OFF_BYTE_ORDER, rd, rs);
        check({31'h0, rd === `BYTE_ORDER_PATTERN}, 32'h0);
        rd_chk(`OFF_RESET_CONTROL, 32'h0);
        wait_ready;
        tally_and_finish;
    end
endmodule // tb
